// file: cbcs_core.sv
// core bus cycle sequencer: branch, data, status transfer and multiply cycles
// Summary of operation
// RULE1 - request and sequential flags announce next cycle
// RULE2 - address and strobes describe their own cycle
// RULE3 - branch cycle one prefetches from pc+8
// RULE4 - cycle two fetches target, saves link
// RULE5 - cycle three fetches target+4, link minus 4
// RULE6 - branch cycles are word opcode reads
// RULE7 - data operation takes one cycle with prefetch
// RULE8 - compares write flags only, no result
// RULE9 - register shift adds cycle, then internal
// RULE10 - address held across internal shift cycle
// RULE11 - pc write flushes, fetch from alu
// RULE12 - refill before execution, exceptions locked out
// RULE13 - status transfers time as data, no pc
// RULE14 - early terminating two bit booth multiply
// RULE15 - first multiply cycle loads accumulator or zero
// RULE16 - booth adds, subtracts or passes shifted multiplicand
// RULE17 - multiplier shifts two bits, ends at zero
// RULE18 - later multiply cycles internal, address pc+12
// RULE19 - final multiply cycle announces sequential prefetch
`timescale 1ns/100ps
module cbcs_core (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic instr_valid,
	input wire cbcs_pkg::cbcs_instr_s instr,
	output cbcs_pkg::cbcs_bus_s bus_q,
	output logic ready_q,
	output logic dest_we_q,
	output logic flags_we_q,
	output logic link_we_q,
	output logic [31:0] link_register_q,
	output logic [7:0] shamt_q,
	output logic shamt_we_q,
	output logic flush_q,
	output logic addr_from_alu_q,
	output logic exc_lock_q,
	output logic [31:0] fetch_next_q,
	output cbcs_pkg::cbcs_booth_e booth_op_q,
	output logic [5:0] booth_shift_q,
	output logic [31:0] product_q
);
	cbcs_pkg::cbcs_state_e state_q, state_d;
	cbcs_pkg::cbcs_bus_s bus_d;
	cbcs_pkg::cbcs_kind_e kind_q, kind_d;
	cbcs_pkg::cbcs_booth_e booth_op_d;
	logic ready_d, dest_we_d, flags_we_d, link_we_d, shamt_we_d, flush_d, addr_from_alu_d, exc_lock_d;
	logic link_q, link_d, sreg_q, sreg_d, dpc_q, dpc_d, cmp_q, cmp_d;
	logic [31:0] pc_q, pc_d, tgt_q, tgt_d, link_register_d, fetch_next_d, product_d;
	logic [31:0] mplier_q, mplier_d, mcand_q, mcand_d, mshift;
	logic [7:0] shamt_d;
	logic [5:0] booth_shift_d;
	logic [cbcs_pkg::CBCS_CNT_W-1:0] n_q, n_d;
	logic borrow_q, borrow_d, accept, last_step;

	assign accept = instr_valid && ready_q;

	always_comb begin
		state_d = state_q;
		bus_d = bus_q;
		kind_d = kind_q;
		link_d = link_q;
		sreg_d = sreg_q;
		dpc_d = dpc_q;
		cmp_d = cmp_q;
		pc_d = pc_q;
		tgt_d = tgt_q;
		link_register_d = link_register_q;
		fetch_next_d = fetch_next_q;
		product_d = product_q;
		mplier_d = mplier_q;
		mcand_d = mcand_q;
		n_d = n_q;
		borrow_d = borrow_q;
		shamt_d = shamt_q;
		booth_shift_d = booth_shift_q;
		booth_op_d = cbcs_pkg::CBCS_B_PASS;
		dest_we_d = 1'b0;
		flags_we_d = 1'b0;
		link_we_d = 1'b0;
		shamt_we_d = 1'b0;
		flush_d = 1'b0;
		addr_from_alu_d = 1'b0;
		exc_lock_d = exc_lock_q;
		mshift = 32'h0;
		last_step = 1'b0;
		// RULE2 strobes of own cycle
		// RULE6 word reads only
		bus_d.byte_word_select_low = 1'b1;
		bus_d.read_write_select_low = 1'b0;
		case (state_q)
			cbcs_pkg::CBCS_ST_IDLE: begin
				exc_lock_d = 1'b0;
				bus_d.memory_request_low = 1'b1;
				bus_d.sequential_cycle_flag = 1'b0;
				bus_d.opcode_fetch_low = 1'b1;
				if (accept) begin
					kind_d = instr.kind;
					link_d = instr.link;
					sreg_d = instr.shift_by_reg;
					// RULE13 no pc for status transfer
					dpc_d = instr.dest_pc && (instr.kind == cbcs_pkg::CBCS_K_DATA) && !instr.compare;
					cmp_d = instr.compare;
					pc_d = instr.pc;
					tgt_d = instr.target;
					// RULE3 prefetch from pc+8
					bus_d.addr = instr.pc + cbcs_pkg::CBCS_PC_AHEAD;
					bus_d.opcode_fetch_low = 1'b0;
					fetch_next_d = instr.pc + cbcs_pkg::CBCS_PC_NEXT;
					case (instr.kind)
						cbcs_pkg::CBCS_K_BRANCH: begin
							// RULE1 announce non-sequential target
							bus_d.memory_request_low = 1'b0;
							state_d = cbcs_pkg::CBCS_ST_SECOND;
						end
						cbcs_pkg::CBCS_K_MUL: begin
							// RULE15 accumulate or zero
							product_d = instr.accumulate ? instr.accum : 32'h0;
							// RULE14 multiplier into booth shifter
							mplier_d = instr.multiplier_operand_reg;
							mcand_d = instr.multiplicand_operand_reg;
							borrow_d = 1'b0;
							n_d = '0;
							state_d = cbcs_pkg::CBCS_ST_BOOTH;
						end
						default: begin
							if (instr.shift_by_reg) begin
								// RULE9 latch shift amount
								shamt_d = instr.shift_src[cbcs_pkg::CBCS_SHAMT_W-1:0];
								shamt_we_d = 1'b1;
								state_d = cbcs_pkg::CBCS_ST_SECOND;
							end else begin
								// RULE7 single cycle operation
								bus_d.memory_request_low = 1'b0;
								bus_d.sequential_cycle_flag = !dpc_d;
								// RULE8 compares set flags only
								dest_we_d = !instr.compare;
								flags_we_d = instr.compare;
								if (dpc_d) begin
									exc_lock_d = 1'b1;
									state_d = cbcs_pkg::CBCS_ST_SECOND;
								end
							end
						end
					endcase
				end
			end
			cbcs_pkg::CBCS_ST_SECOND: begin
				bus_d.memory_request_low = 1'b0;
				bus_d.sequential_cycle_flag = 1'b1;
				if (kind_q == cbcs_pkg::CBCS_K_BRANCH || !sreg_q) begin
					// RULE4 fetch target, save return
					bus_d.addr = tgt_q;
					bus_d.opcode_fetch_low = 1'b0;
					// RULE11 flush, address from alu
					flush_d = 1'b1;
					addr_from_alu_d = 1'b1;
					link_we_d = (kind_q == cbcs_pkg::CBCS_K_BRANCH) && link_q;
					link_register_d = pc_q + cbcs_pkg::CBCS_PC_AHEAD;
					state_d = cbcs_pkg::CBCS_ST_THIRD;
				end else begin
					// RULE10 address held at pc+12
					bus_d.addr = pc_q + cbcs_pkg::CBCS_PC_NEXT;
					bus_d.opcode_fetch_low = 1'b1;
					bus_d.sequential_cycle_flag = !dpc_q;
					dest_we_d = !cmp_q;
					flags_we_d = cmp_q;
					exc_lock_d = dpc_q;
					state_d = dpc_q ? cbcs_pkg::CBCS_ST_THIRD : cbcs_pkg::CBCS_ST_IDLE;
				end
			end
			cbcs_pkg::CBCS_ST_THIRD: begin
				bus_d.memory_request_low = 1'b0;
				bus_d.sequential_cycle_flag = 1'b1;
				bus_d.opcode_fetch_low = 1'b0;
				if (kind_q != cbcs_pkg::CBCS_K_BRANCH && sreg_q) begin
					bus_d.addr = tgt_q;
					flush_d = 1'b1;
					addr_from_alu_d = 1'b1;
					state_d = cbcs_pkg::CBCS_ST_FOURTH;
				end else begin
					// RULE5 refill target+4, adjust link
					bus_d.addr = tgt_q + cbcs_pkg::CBCS_WORD;
					link_we_d = (kind_q == cbcs_pkg::CBCS_K_BRANCH) && link_q;
					link_register_d = link_register_q - cbcs_pkg::CBCS_LINK_ADJ;
					fetch_next_d = tgt_q + cbcs_pkg::CBCS_PC_AHEAD;
					state_d = cbcs_pkg::CBCS_ST_IDLE;
				end
			end
			cbcs_pkg::CBCS_ST_FOURTH: begin
				bus_d.memory_request_low = 1'b0;
				bus_d.sequential_cycle_flag = 1'b1;
				bus_d.opcode_fetch_low = 1'b0;
				bus_d.addr = tgt_q + cbcs_pkg::CBCS_WORD;
				// RULE12 next fetch at target+8
				fetch_next_d = tgt_q + cbcs_pkg::CBCS_PC_AHEAD;
				state_d = cbcs_pkg::CBCS_ST_IDLE;
			end
			cbcs_pkg::CBCS_ST_BOOTH: begin
				// RULE18 internal cycle at pc+12
				bus_d.addr = pc_q + cbcs_pkg::CBCS_PC_NEXT;
				bus_d.opcode_fetch_low = 1'b1;
				// RULE16 booth digit selects operation
				booth_shift_d = {n_q, 1'b0};
				case ({mplier_q[1:0], borrow_q})
					3'h1, 3'h2: booth_op_d = cbcs_pkg::CBCS_B_ADD;
					3'h3: begin
						booth_op_d = cbcs_pkg::CBCS_B_ADD;
						booth_shift_d = {n_q, 1'b1};
					end
					3'h4: begin
						booth_op_d = cbcs_pkg::CBCS_B_SUB;
						booth_shift_d = {n_q, 1'b1};
					end
					3'h5, 3'h6: booth_op_d = cbcs_pkg::CBCS_B_SUB;
					default: booth_op_d = cbcs_pkg::CBCS_B_PASS;
				endcase
				mshift = mcand_q << booth_shift_d;
				if (booth_op_d == cbcs_pkg::CBCS_B_ADD) begin
					product_d = product_q + mshift;
				end else if (booth_op_d == cbcs_pkg::CBCS_B_SUB) begin
					product_d = product_q - mshift;
				end
				// RULE17 shift two bits, stop at zero with no borrow
				mplier_d = mplier_q >> cbcs_pkg::CBCS_BOOTH_STEP;
				borrow_d = mplier_q[1];
				n_d = n_q + 1'b1;
				last_step = (mplier_d == 32'h0) && !borrow_d;
				// RULE19 final cycle announces sequential fetch
				bus_d.memory_request_low = !last_step;
				bus_d.sequential_cycle_flag = last_step;
				if (last_step) begin
					dest_we_d = 1'b1;
					state_d = cbcs_pkg::CBCS_ST_IDLE;
				end
			end
			default: begin
				state_d = cbcs_pkg::CBCS_ST_IDLE;
			end
		endcase
		// RULE12 no new instruction before refill
		ready_d = (state_d == cbcs_pkg::CBCS_ST_IDLE);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= cbcs_pkg::CBCS_ST_IDLE;
			bus_q <= cbcs_pkg::CBCS_BUS_RST;
			kind_q <= cbcs_pkg::CBCS_K_BRANCH;
			booth_op_q <= cbcs_pkg::CBCS_B_PASS;
			{ready_q, dest_we_q, flags_we_q, link_we_q, shamt_we_q} <= 5'h10;
			{flush_q, addr_from_alu_q, exc_lock_q, link_q, sreg_q, dpc_q, cmp_q, borrow_q} <= 8'h00;
			pc_q <= cbcs_pkg::CBCS_ADDR_RST;
			tgt_q <= cbcs_pkg::CBCS_ADDR_RST;
			link_register_q <= cbcs_pkg::CBCS_ADDR_RST;
			fetch_next_q <= cbcs_pkg::CBCS_ADDR_RST;
			product_q <= 32'h0;
			mplier_q <= 32'h0;
			mcand_q <= 32'h0;
			shamt_q <= cbcs_pkg::CBCS_SHAMT_RST;
			booth_shift_q <= 6'h0;
			n_q <= '0;
		end else begin
			state_q <= state_d;
			bus_q <= bus_d;
			kind_q <= kind_d;
			booth_op_q <= booth_op_d;
			{ready_q, dest_we_q, flags_we_q, link_we_q, shamt_we_q} <= {ready_d, dest_we_d, flags_we_d, link_we_d,
				shamt_we_d};
			{flush_q, addr_from_alu_q, exc_lock_q, link_q, sreg_q, dpc_q, cmp_q, borrow_q} <= {flush_d,
				addr_from_alu_d, exc_lock_d, link_d, sreg_d, dpc_d, cmp_d, borrow_d};
			pc_q <= pc_d;
			tgt_q <= tgt_d;
			link_register_q <= link_register_d;
			fetch_next_q <= fetch_next_d;
			product_q <= product_d;
			mplier_q <= mplier_d;
			mcand_q <= mcand_d;
			shamt_q <= shamt_d;
			booth_shift_q <= booth_shift_d;
			n_q <= n_d;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic acc_br, acc_mul, acc_sreg, acc_cmp;
	assign acc_br = accept && instr.kind == cbcs_pkg::CBCS_K_BRANCH;
	assign acc_mul = accept && instr.kind == cbcs_pkg::CBCS_K_MUL;
	assign acc_sreg = accept && instr.kind != cbcs_pkg::CBCS_K_BRANCH && !acc_mul && instr.shift_by_reg;
	assign acc_cmp = accept && instr.kind == cbcs_pkg::CBCS_K_DATA && instr.compare && !instr.shift_by_reg;

	// RULE3 branch prefetch address
	branch_prefetch_a: assert property (acc_br |=> bus_q.addr == $past(instr.pc) + cbcs_pkg::CBCS_PC_AHEAD
		&& !bus_q.memory_request_low && !bus_q.sequential_cycle_flag) // RULE3
		else $error("branch first cycle wrong");
	// RULE4 target fetch and link
	branch_target_a: assert property (acc_br |=> ##1 bus_q.addr == $past(instr.target, 2)
		&& link_we_q == $past(instr.link, 2) && link_register_q == $past(instr.pc, 2) + 32'h8) // RULE4
		else $error("branch target cycle wrong");
	// RULE5 refill and link adjust
	branch_refill_a: assert property (acc_br |=> ##2 bus_q.addr == $past(instr.target, 3) + 32'h4
		&& link_register_q == $past(instr.pc, 3) + 32'h4 && ready_q) // RULE5
		else $error("branch third cycle wrong");
	// RULE6 word opcode reads
	branch_fetch_a: assert property (acc_br |=> (!bus_q.opcode_fetch_low && bus_q.byte_word_select_low
		&& !bus_q.read_write_select_low)[*3]) // RULE6
		else $error("branch cycle not a word fetch");
	// RULE8 compare writes flags only
	compare_only_a: assert property (acc_cmp |=> flags_we_q && !dest_we_q && ready_q) // RULE8
		else $error("compare wrote a register");
	// RULE10 internal cycle address is prefetch address plus 4
	shift_hold_a: assert property (acc_sreg |=> bus_q.memory_request_low ##1
		(!bus_q.memory_request_low && bus_q.opcode_fetch_low && bus_q.addr == $past(bus_q.addr) + 32'h4)) // RULE10
		else $error("shift cycle address not held");
	// RULE12 lock while refilling
	refill_lock_a: assert property (flush_q && kind_q != cbcs_pkg::CBCS_K_BRANCH |-> exc_lock_q
		&& !ready_q) // RULE12
		else $error("exceptions open during refill");
	// RULE15 accumulator or zero
	mul_init_a: assert property (acc_mul |=> product_q == ($past(instr.accumulate) ? $past(instr.accum) : 32'h0)
		&& bus_q.memory_request_low) // RULE15
		else $error("multiply init wrong");
	// RULE17 multiplier shifts by two
	mul_shift_a: assert property (state_q == cbcs_pkg::CBCS_ST_BOOTH |=> mplier_q == $past(mplier_q) >> 2) // RULE17
		else $error("multiplier not shifted");
	// RULE18 internal booth cycles
	mul_internal_a: assert property (state_q == cbcs_pkg::CBCS_ST_BOOTH && $past(state_q) == cbcs_pkg::CBCS_ST_BOOTH
		|-> bus_q.opcode_fetch_low && bus_q.addr == pc_q + 32'hC) // RULE18
		else $error("booth cycle not internal");
	// RULE19 final cycle announces fetch
	mul_end_a: assert property (state_q == cbcs_pkg::CBCS_ST_BOOTH && state_d == cbcs_pkg::CBCS_ST_IDLE
		|=> !bus_q.memory_request_low && bus_q.sequential_cycle_flag && ready_q && dest_we_q) // RULE19
		else $error("multiply end wrong");

	branch_link_c: cover property (acc_br && instr.link ##3 link_we_q);
	shift_pc_c: cover property (acc_sreg && instr.dest_pc ##4 ready_q);
	mul_long_c: cover property (acc_mul ##3 state_q == cbcs_pkg::CBCS_ST_BOOTH);
endmodule

// file: cbcs_mem_model.sv
// memory manager model: watches bus cycles and counts internal-then-access pairs at one address
`timescale 1ns/100ps
module cbcs_mem_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire cbcs_pkg::cbcs_bus_s bus,
	output logic [15:0] merge_count
);
	logic req_q;
	logic int_q;
	logic [31:0] addr_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_q <= 1'b0;
			int_q <= 1'b0;
			addr_q <= 32'h0;
			merge_count <= 16'h0;
		end else begin
			req_q <= !bus.memory_request_low;
			int_q <= !req_q;
			addr_q <= bus.addr;
			if (req_q && int_q && bus.addr == addr_q) begin
				merge_count <= merge_count + 16'h1;
			end
		end
	end
endmodule

// file: cbcs_pkg.sv
// package: types and constants of the core bus cycle sequencer
package cbcs_pkg;
	localparam logic [31:0] CBCS_WORD = 32'h4;
	localparam logic [31:0] CBCS_PC_AHEAD = 32'h8;
	localparam logic [31:0] CBCS_PC_NEXT = 32'hC;
	localparam logic [31:0] CBCS_LINK_ADJ = 32'h4;
	localparam int CBCS_SHAMT_W = 8;
	localparam int CBCS_BOOTH_STEP = 2;
	localparam int CBCS_CNT_W = 5;
	localparam logic [31:0] CBCS_ADDR_RST = 32'h0;
	localparam logic [7:0] CBCS_SHAMT_RST = 8'h0;

	typedef enum logic [1:0] {
		CBCS_K_BRANCH = 2'h0,
		CBCS_K_DATA = 2'h1,
		CBCS_K_PSR = 2'h2,
		CBCS_K_MUL = 2'h3
	} cbcs_kind_e;

	// gray along idle, second, third, fourth; booth off idle
	typedef enum logic [2:0] {
		CBCS_ST_IDLE = 3'h0,
		CBCS_ST_SECOND = 3'h1,
		CBCS_ST_THIRD = 3'h3,
		CBCS_ST_FOURTH = 3'h7,
		CBCS_ST_BOOTH = 3'h2
	} cbcs_state_e;

	typedef enum logic [1:0] {
		CBCS_B_PASS = 2'h0,
		CBCS_B_ADD = 2'h1,
		CBCS_B_SUB = 2'h2
	} cbcs_booth_e;

	typedef struct packed {
		cbcs_kind_e kind;
		logic link;
		logic shift_by_reg;
		logic dest_pc;
		logic compare;
		logic accumulate;
		logic [31:0] pc;
		logic [31:0] target;
		logic [31:0] shift_src;
		logic [31:0] multiplier_operand_reg;
		logic [31:0] multiplicand_operand_reg;
		logic [31:0] accum;
	} cbcs_instr_s;

	typedef struct packed {
		logic [31:0] addr;
		logic memory_request_low;
		logic sequential_cycle_flag;
		logic byte_word_select_low;
		logic read_write_select_low;
		logic opcode_fetch_low;
	} cbcs_bus_s;

	localparam cbcs_bus_s CBCS_BUS_RST = '{addr: CBCS_ADDR_RST, memory_request_low: 1'b1,
		sequential_cycle_flag: 1'b0, byte_word_select_low: 1'b1, read_write_select_low: 1'b0,
		opcode_fetch_low: 1'b1};
endpackage

// file: cbcs_tb.sv
// testbench: bus cycle sequences of the core sequencer
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic instr_valid = 1'b0;
	cbcs_pkg::cbcs_instr_s instr = '0;
	cbcs_pkg::cbcs_bus_s bus_q;
	logic ready_q, dest_we_q, flags_we_q, link_we_q, shamt_we_q, flush_q, addr_from_alu_q, exc_lock_q;
	logic [31:0] link_register_q, fetch_next_q, product_q;
	logic [7:0] shamt_q;
	cbcs_pkg::cbcs_booth_e booth_op_q;
	logic [5:0] booth_shift_q;
	logic [15:0] merge_count;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	cbcs_core dut_u (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr), .bus_q(bus_q),
		.ready_q(ready_q), .dest_we_q(dest_we_q), .flags_we_q(flags_we_q), .link_we_q(link_we_q),
		.link_register_q(link_register_q), .shamt_q(shamt_q), .shamt_we_q(shamt_we_q), .flush_q(flush_q),
		.addr_from_alu_q(addr_from_alu_q), .exc_lock_q(exc_lock_q), .fetch_next_q(fetch_next_q),
		.booth_op_q(booth_op_q), .booth_shift_q(booth_shift_q), .product_q(product_q));
	cbcs_mem_model mem_u (.clk(clk), .sys_rst(sys_rst), .bus(bus_q), .merge_count(merge_count));

	always #2 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			end_of_test();
		end
	end

	task end_of_test;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task chk(input logic [63:0] s, input logic [63:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, s, e);
		end
	endtask

	task cb(input logic [31:0] a, input logic mq, input logic sq, input logic op);
		chk({bus_q.addr, bus_q.memory_request_low, bus_q.sequential_cycle_flag, bus_q.byte_word_select_low,
			bus_q.read_write_select_low, bus_q.opcode_fetch_low}, {a, mq, sq, 1'b1, 1'b0, op});
	endtask

	function automatic cbcs_pkg::cbcs_instr_s mk(input cbcs_pkg::cbcs_kind_e k, input logic [4:0] f,
		input logic [31:0] pc, input logic [31:0] tg);
		mk = '0;
		mk.kind = k;
		{mk.link, mk.shift_by_reg, mk.dest_pc, mk.compare, mk.accumulate} = f;
		mk.pc = pc;
		mk.target = tg;
	endfunction

	task go(input cbcs_pkg::cbcs_instr_s i);
		int k;
		for (k = 0; k < 40 && ready_q !== 1'b1; k++) @(negedge clk);
		instr = i;
		instr_valid = 1'b1;
		@(negedge clk);
	endtask

	task stop;
		instr_valid = 1'b0;
	endtask

	task t_branch(input logic lk);
		go(mk(cbcs_pkg::CBCS_K_BRANCH, {lk, 4'h0}, 32'h100, 32'h2000));
		stop();
		cb(32'h108, 1'b0, 1'b0, 1'b0);
		@(negedge clk);
		cb(32'h2000, 1'b0, 1'b1, 1'b0);
		chk({flush_q, link_we_q, lk ? link_register_q : 32'h0}, {1'b1, lk, lk ? 32'h108 : 32'h0});
		@(negedge clk);
		cb(32'h2004, 1'b0, 1'b1, 1'b0);
		chk({link_we_q, lk ? link_register_q : 32'h0}, {lk, lk ? 32'h104 : 32'h0});
		chk({ready_q, fetch_next_q}, {1'b1, 32'h2008});
		@(negedge clk);
		$display("branch test done");
	endtask

	task t_data(input cbcs_pkg::cbcs_kind_e k, input logic [4:0] f);
		go(mk(k, f, 32'h200, 32'h0));
		stop();
		cb(32'h208, 1'b0, 1'b1, 1'b0);
		chk({dest_we_q, flags_we_q, ready_q, flush_q, exc_lock_q}, {!f[1], f[1], 3'b100});
		chk(fetch_next_q, 32'h20C);
		@(negedge clk);
		$display("data test done");
	endtask

	task t_pcw;
		go(mk(cbcs_pkg::CBCS_K_DATA, 5'b00100, 32'h300, 32'h3000));
		stop();
		cb(32'h308, 1'b0, 1'b0, 1'b0);
		chk({dest_we_q, exc_lock_q}, 2'b11);
		@(negedge clk);
		cb(32'h3000, 1'b0, 1'b1, 1'b0);
		chk({flush_q, addr_from_alu_q, exc_lock_q, ready_q}, 4'b1110);
		@(negedge clk);
		cb(32'h3004, 1'b0, 1'b1, 1'b0);
		chk({exc_lock_q, ready_q, fetch_next_q}, {2'b11, 32'h3008});
		@(negedge clk);
		chk(exc_lock_q, 1'b0);
		$display("pc write test done");
	endtask

	task t_shift;
		cbcs_pkg::cbcs_instr_s i;
		logic [15:0] m0;
		m0 = merge_count;
		i = mk(cbcs_pkg::CBCS_K_DATA, 5'b01000, 32'h400, 32'h0);
		i.shift_src = 32'h123456AB;
		go(i);
		cb(32'h408, 1'b1, 1'b0, 1'b0);
		chk({shamt_we_q, shamt_q}, {1'b1, 8'hAB});
		@(negedge clk);
		cb(32'h40C, 1'b0, 1'b1, 1'b1);
		chk({dest_we_q, ready_q}, 2'b11);
		go(mk(cbcs_pkg::CBCS_K_DATA, 5'b00000, 32'h404, 32'h0));
		stop();
		cb(32'h40C, 1'b0, 1'b1, 1'b0);
		@(negedge clk);
		chk(merge_count, m0 + 16'h1);
		$display("shift test done");
	endtask

	task t_shift_pc;
		cbcs_pkg::cbcs_instr_s i;
		i = mk(cbcs_pkg::CBCS_K_DATA, 5'b01100, 32'h600, 32'h6000);
		i.shift_src = 32'h00000005;
		go(i);
		stop();
		cb(32'h608, 1'b1, 1'b0, 1'b0);
		chk({shamt_we_q, shamt_q}, {1'b1, 8'h05});
		@(negedge clk);
		cb(32'h60C, 1'b0, 1'b0, 1'b1);
		chk({dest_we_q, exc_lock_q, ready_q}, 3'b110);
		@(negedge clk);
		cb(32'h6000, 1'b0, 1'b1, 1'b0);
		chk({flush_q, addr_from_alu_q, exc_lock_q, ready_q}, 4'b1110);
		@(negedge clk);
		cb(32'h6004, 1'b0, 1'b1, 1'b0);
		chk({exc_lock_q, ready_q, fetch_next_q}, {2'b11, 32'h6008});
		@(negedge clk);
		chk(exc_lock_q, 1'b0);
		$display("shift pc write test done");
	endtask

	task t_mul(input logic [31:0] mr, input logic [31:0] md, input logic [31:0] ac, input logic acc);
		cbcs_pkg::cbcs_instr_s i;
		logic [31:0] m, p;
		logic b, last;
		logic [2:0] d;
		logic [1:0] op;
		logic [5:0] sh;
		int n;
		i = mk(cbcs_pkg::CBCS_K_MUL, {4'h0, acc}, 32'h500, 32'h0);
		i.multiplier_operand_reg = mr;
		i.multiplicand_operand_reg = md;
		i.accum = ac;
		p = acc ? ac : 32'h0;
		m = mr;
		b = 1'b0;
		n = 0;
		go(i);
		stop();
		cb(32'h508, 1'b1, 1'b0, 1'b0);
		chk(product_q, p);
		do begin
			@(negedge clk);
			d = {m[1:0], b};
			sh = 6'(2 * n + ((d == 3'h3 || d == 3'h4) ? 1 : 0));
			op = (d == 3'h0 || d == 3'h7) ? cbcs_pkg::CBCS_B_PASS : (d < 3'h4 ? cbcs_pkg::CBCS_B_ADD : cbcs_pkg::CBCS_B_SUB);
			p = (op == cbcs_pkg::CBCS_B_ADD) ? p + (md << sh) : ((op == cbcs_pkg::CBCS_B_SUB) ? p - (md << sh) : p);
			b = d[2];
			m = m >> 2;
			n++;
			last = (m == 32'h0 && !b);
			cb(32'h50C, !last, last, 1'b1);
			chk({booth_op_q, booth_shift_q}, {op, sh});
			chk({dest_we_q, ready_q}, {last, last});
		end while (!last && n < 20);
		@(negedge clk);
		chk(product_q, p);
		$display("multiply test done");
	endtask

	initial begin
		repeat (3) @(negedge clk);
		sys_rst = 1'b0;
		chk({bus_q, ready_q}, {cbcs_pkg::CBCS_BUS_RST, 1'b1});
		t_branch(1'b1);
		t_branch(1'b0);
		t_data(cbcs_pkg::CBCS_K_DATA, 5'b00000);
		t_data(cbcs_pkg::CBCS_K_DATA, 5'b00010);
		t_data(cbcs_pkg::CBCS_K_PSR, 5'b00100);
		t_data(cbcs_pkg::CBCS_K_DATA, 5'b00110);
		t_pcw();
		t_shift();
		t_shift_pc();
		t_mul(32'h0, 32'h7, 32'h5, 1'b0);
		t_mul(32'h1, 32'h7, 32'h5, 1'b1);
		t_mul(32'hB, 32'h7, 32'h5, 1'b1);
		t_mul(32'hFFFFFFFF, 32'h3, 32'h10, 1'b1);
		end_of_test();
	end
endmodule
